// File: fog_regs.vh
/*
  Register map, reset values, field positions and timing figures for the
  fan output and pin configuration register bank.
  Assumes 8-bit registers reached by an 8-bit byte address.
*/
`ifndef FOG_REGS_VH
`define FOG_REGS_VH

// ==========================================================
// Register offsets
`define FOG_ADDR_MODE_CTRL    8'h00
`define FOG_ADDR_PIN_ENABLE   8'h01
`define FOG_ADDR_FAN_PRESCALE 8'h03
`define FOG_ADDR_ANALOG_LEVEL 8'h04
`define FOG_ADDR_PWM_DUTY     8'h05
`define FOG_ADDR_FACTORY_ONE  8'h06
`define FOG_ADDR_PIN_REF_CFG  8'h07
`define FOG_ADDR_IO_0_3_CFG   8'h08
`define FOG_ADDR_PIN_STATE    8'h1F

// ==========================================================
// Reset values
`define FOG_RST_MODE_CTRL    8'h00
`define FOG_RST_PIN_ENABLE   8'h00
`define FOG_RST_FAN_PRESCALE 8'h55
`define FOG_RST_ANALOG_LEVEL 8'hFF
`define FOG_RST_PWM_DUTY     8'h00
`define FOG_RST_FACTORY_ONE  8'h00
`define FOG_RST_PIN_REF_CFG  8'h00
`define FOG_RST_IO_0_3_CFG   8'h00
`define FOG_READ_IDLE        8'h00

// ==========================================================
// Field positions and masks
`define FOG_MODE_DAC_AUTO_BIT 5
`define FOG_MODE_PWM_AUTO_BIT 6
`define FOG_MODE_WR_MASK      8'h60
`define FOG_PIN_ENABLE_MASK   8'h0F
`define FOG_PWM_WR_MASK       8'hF0
`define FOG_CFG3_WR_MASK      8'hC7
`define FOG_CFG3_GPIO_SEL_BIT 0
`define FOG_CFG3_CI_CLEAR_BIT 1
`define FOG_CFG3_VREF_BIT     2
`define FOG_CFG3_DIR_BIT      6
`define FOG_CFG3_POL_BIT      7
`define FOG_PIN_STATE_G16_BIT 4

// ==========================================================
// Timing
`define FOG_CLK_HZ      100000000
`define FOG_BASE_OSC_HZ 22500
`define FOG_PWM_STEPS   4'hF

`endif

// File: fog_tach_div.v
/*
  Tach measurement clock prescaler for four fans: turns the base oscillator
  tick into one tick per 1, 2, 4 or 8 base ticks for each fan.
  Assumes base_tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps

module fog_tach_div #(
  parameter FANS = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control
  input wire base_tick,
  input wire [2*FANS-1:0] prescale,
  // Per-fan measurement ticks
  output reg [FANS-1:0] fan_tick_q
);

  // ==========================================================
  // Shared divide chain
  reg [2:0] chain_q;
  integer i;

  // Low chain bits that must be zero for a tick; code 3 wraps to all ones
  function [2:0] ratio_mask;
    input [1:0] code;
    begin
      ratio_mask = (3'h1 << code) - 3'h1;
    end
  endfunction

  always @(posedge clock) begin
    if (!rst_n) begin
      chain_q <= 3'h0;
    end else if (base_tick) begin
      chain_q <= chain_q + 3'h1;
    end
  end

  // code to ratio; tick rate is base over ratio
  always @(posedge clock) begin
    if (!rst_n) begin
      fan_tick_q <= {FANS{1'b0}};
    end else begin
      for (i = 0; i < FANS; i = i + 1) begin
        fan_tick_q[i] <= base_tick && ((chain_q & ratio_mask(prescale[2*i +: 2])) == 3'h0);
      end
    end
  end

endmodule // fog_tach_div

// File: fog_config_regs.v
/*
  Fan output and pin configuration register bank: tach prescalers for fans
  4 to 7, analog and pulse-width fan levels, shared thermal/general pin,
  reference select, intrusion clear and direction/polarity of pins 0 to 3.
  Assumes a single-cycle register port and pins that arrive asynchronously.
*/
`timescale 1ns/1ps
`include "fog_regs.vh"

module fog_config_regs #(
  parameter BASE_DIV = `FOG_CLK_HZ / `FOG_BASE_OSC_HZ,
  parameter PWM_STEP_CYC = 100,
  parameter IO_PINS = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  // Automatic fan control loop
  input wire [7:0] auto_dac_level,
  input wire [3:0] auto_pwm_code,
  output reg [3:0] dac_min_speed_q,
  output reg [3:0] pwm_min_speed_q,
  // Fan outputs
  output reg [7:0] dac_level_q,
  output reg pwm_out_q,
  // Tach measurement
  output wire [3:0] fan_tick,
  output reg [IO_PINS-1:0] tach_in_q,
  // Thermal alarm and general pin 16
  input wire thermal_alarm_req,
  input wire general_io_16_value,
  output reg general_io_16_state_q,
  input wire pin16_in,
  output reg pin16_out_q,
  output reg pin16_oe_n_q,
  // General pins 0 to 3
  input wire [IO_PINS-1:0] io_value,
  output reg [IO_PINS-1:0] io_state_q,
  input wire [IO_PINS-1:0] io_pin_in,
  output reg [IO_PINS-1:0] io_pin_out_q,
  output reg [IO_PINS-1:0] io_pin_oe_n_q,
  // Miscellaneous controls
  output reg chassis_intrusion_latch_clear_q,
  output reg vref_high_sel_q,
  output reg [7:0] factory_byte_q
);

  // ==========================================================
  // Helpers

  // Polarity: logical assert to pin level and back are the same map
  function fog_pol;
    input val;
    input active_high;
    begin
      fog_pol = active_high ? val : ~val;
    end
  endfunction

  function fog_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      fog_hit = (addr == target);
    end
  endfunction

  // ==========================================================
  // Register storage
  reg [7:0] mode_ctrl_q;
  reg [7:0] pin_enable_q;
  reg [7:0] fan_prescaler_upper_group_q;
  reg [7:0] analog_fan_level_q;
  reg [7:0] pulse_width_fan_duty_q;
  reg [7:0] pin_and_reference_config_q;
  reg [7:0] io_pins_0_3_config_q;
  wire [7:0] pin_state;

  always @(posedge clock) begin
    if (!rst_n) begin
      mode_ctrl_q <= `FOG_RST_MODE_CTRL;
      pin_enable_q <= `FOG_RST_PIN_ENABLE;
      fan_prescaler_upper_group_q <= `FOG_RST_FAN_PRESCALE;
      analog_fan_level_q <= `FOG_RST_ANALOG_LEVEL;
      pulse_width_fan_duty_q <= `FOG_RST_PWM_DUTY;
      factory_byte_q <= `FOG_RST_FACTORY_ONE;
      pin_and_reference_config_q <= `FOG_RST_PIN_REF_CFG;
      io_pins_0_3_config_q <= `FOG_RST_IO_0_3_CFG;
    end else if (reg_wr) begin
      if (fog_hit(reg_addr, `FOG_ADDR_MODE_CTRL)) begin
        mode_ctrl_q <= reg_wdata & `FOG_MODE_WR_MASK;
      end
      if (fog_hit(reg_addr, `FOG_ADDR_PIN_ENABLE)) begin
        pin_enable_q <= reg_wdata & `FOG_PIN_ENABLE_MASK;
      end
      if (fog_hit(reg_addr, `FOG_ADDR_FAN_PRESCALE)) begin
        fan_prescaler_upper_group_q <= reg_wdata;
      end
      if (fog_hit(reg_addr, `FOG_ADDR_ANALOG_LEVEL)) begin
        analog_fan_level_q <= reg_wdata;
      end
      // duty lives in the upper nibble
      if (fog_hit(reg_addr, `FOG_ADDR_PWM_DUTY)) begin
        pulse_width_fan_duty_q <= reg_wdata & `FOG_PWM_WR_MASK;
      end
      // Stored anyway; host software is expected to leave it alone
      if (fog_hit(reg_addr, `FOG_ADDR_FACTORY_ONE)) begin
        factory_byte_q <= reg_wdata;
      end
      if (fog_hit(reg_addr, `FOG_ADDR_PIN_REF_CFG)) begin
        pin_and_reference_config_q <= reg_wdata & `FOG_CFG3_WR_MASK;
      end
      if (fog_hit(reg_addr, `FOG_ADDR_IO_0_3_CFG)) begin
        io_pins_0_3_config_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Read port: data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata_q <= `FOG_READ_IDLE;
    end else if (reg_rd) begin
      case (reg_addr)
        `FOG_ADDR_MODE_CTRL: reg_rdata_q <= mode_ctrl_q;
        `FOG_ADDR_PIN_ENABLE: reg_rdata_q <= pin_enable_q;
        `FOG_ADDR_FAN_PRESCALE: reg_rdata_q <= fan_prescaler_upper_group_q;
        `FOG_ADDR_ANALOG_LEVEL: reg_rdata_q <= analog_fan_level_q;
        `FOG_ADDR_PWM_DUTY: reg_rdata_q <= pulse_width_fan_duty_q;
        `FOG_ADDR_FACTORY_ONE: reg_rdata_q <= factory_byte_q;
        `FOG_ADDR_PIN_REF_CFG: reg_rdata_q <= pin_and_reference_config_q;
        `FOG_ADDR_IO_0_3_CFG: reg_rdata_q <= io_pins_0_3_config_q;
        `FOG_ADDR_PIN_STATE: reg_rdata_q <= pin_state;
        default: reg_rdata_q <= `FOG_READ_IDLE;
      endcase
    end else begin
      reg_rdata_q <= `FOG_READ_IDLE;
    end
  end

  // ==========================================================
  // Named control bits
  wire dac_auto = mode_ctrl_q[`FOG_MODE_DAC_AUTO_BIT];
  wire pwm_auto = mode_ctrl_q[`FOG_MODE_PWM_AUTO_BIT];
  wire g16_sel = pin_and_reference_config_q[`FOG_CFG3_GPIO_SEL_BIT];
  wire g16_dir = pin_and_reference_config_q[`FOG_CFG3_DIR_BIT];
  wire g16_pol = pin_and_reference_config_q[`FOG_CFG3_POL_BIT];

  // ==========================================================
  // Analog fan output
  always @(posedge clock) begin
    if (!rst_n) begin
      dac_level_q <= `FOG_RST_ANALOG_LEVEL;
      dac_min_speed_q <= 4'h0;
    end else begin
      // automatic loop or register; full byte in manual mode
      dac_level_q <= dac_auto ? auto_dac_level : analog_fan_level_q;
      // loop floor is the upper nibble only
      dac_min_speed_q <= analog_fan_level_q[7:4];
    end
  end

  // ==========================================================
  // Pulse-width fan output: fifteen slots per period
  reg [15:0] pwm_div_q;
  reg [3:0] pwm_slot_q;
  reg [3:0] pwm_code_q;
  wire pwm_step = (pwm_div_q == PWM_STEP_CYC[15:0] - 16'h1);

  always @(posedge clock) begin
    if (!rst_n) begin
      pwm_div_q <= 16'h0;
      pwm_slot_q <= 4'h0;
      pwm_code_q <= 4'h0;
      pwm_out_q <= 1'b0;
      pwm_min_speed_q <= 4'h0;
    end else begin
      pwm_div_q <= pwm_step ? 16'h0 : pwm_div_q + 16'h1;
      if (pwm_step) begin
        if (pwm_slot_q == `FOG_PWM_STEPS - 4'h1) begin
          pwm_slot_q <= 4'h0;
          // code sampled per period so a change never splits one
          pwm_code_q <= pwm_auto ? auto_pwm_code : pulse_width_fan_duty_q[7:4];
        end else begin
          pwm_slot_q <= pwm_slot_q + 4'h1;
        end
      end
      // high for code of fifteen slots; 15 never drops
      pwm_out_q <= (pwm_slot_q < pwm_code_q);
      pwm_min_speed_q <= pulse_width_fan_duty_q[7:4];
    end
  end

  // ==========================================================
  // Base oscillator and tach prescalers
  reg [15:0] base_div_q;
  wire base_tick = (base_div_q == BASE_DIV[15:0] - 16'h1);

  // base rate from the system clock
  always @(posedge clock) begin
    if (!rst_n) begin
      base_div_q <= 16'h0;
    end else begin
      base_div_q <= base_tick ? 16'h0 : base_div_q + 16'h1;
    end
  end

  fog_tach_div #(
    .FANS(4)
  ) u_tach_div (
    .clock(clock),
    .rst_n(rst_n),
    .base_tick(base_tick),
    .prescale(fan_prescaler_upper_group_q),
    .fan_tick_q(fan_tick)
  );

  // ==========================================================
  // Pin input synchronisers: a change counts once stages 2 and 3 agree
  reg [IO_PINS:0] sync1_q;
  reg [IO_PINS:0] sync2_q;
  reg [IO_PINS:0] sync3_q;
  reg [IO_PINS:0] pin_level_q;
  integer k;

  always @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= {(IO_PINS+1){1'b1}};
      sync2_q <= {(IO_PINS+1){1'b1}};
      sync3_q <= {(IO_PINS+1){1'b1}};
      pin_level_q <= {(IO_PINS+1){1'b1}};
    end else begin
      sync1_q <= {pin16_in, io_pin_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (k = 0; k <= IO_PINS; k = k + 1) begin
        if (sync2_q[k] == sync3_q[k]) begin
          pin_level_q[k] <= sync3_q[k];
        end
      end
    end
  end

  // ==========================================================
  // Shared pin: thermal alarm or general pin 16
  always @(posedge clock) begin
    if (!rst_n) begin
      pin16_out_q <= 1'b0;
      pin16_oe_n_q <= 1'b1;
      general_io_16_state_q <= 1'b0;
    end else begin
      if (!g16_sel) begin
        // Open-drain thermal alarm: pull low only while the alarm holds
        pin16_out_q <= 1'b0;
        pin16_oe_n_q <= ~thermal_alarm_req;
        general_io_16_state_q <= 1'b0;
      end else begin
        // level map; drive only as an output
        pin16_out_q <= fog_pol(general_io_16_value, g16_pol);
        pin16_oe_n_q <= ~g16_dir;
        general_io_16_state_q <= g16_dir ? general_io_16_value : fog_pol(pin_level_q[IO_PINS], g16_pol);
      end
    end
  end

  // ==========================================================
  // General pins 0 to 3, shared with tach inputs
  integer p;

  always @(posedge clock) begin
    if (!rst_n) begin
      io_pin_out_q <= {IO_PINS{1'b0}};
      io_pin_oe_n_q <= {IO_PINS{1'b1}};
      io_state_q <= {IO_PINS{1'b0}};
      tach_in_q <= {IO_PINS{1'b0}};
    end else begin
      for (p = 0; p < IO_PINS; p = p + 1) begin
        // enabled pins are general pins, others feed tach
        if (pin_enable_q[p]) begin
          io_pin_out_q[p] <= fog_pol(io_value[p], io_pins_0_3_config_q[2*p+1]);
          io_pin_oe_n_q[p] <= ~io_pins_0_3_config_q[2*p];
          io_state_q[p] <= io_pins_0_3_config_q[2*p] ? io_value[p]
                           : fog_pol(pin_level_q[p], io_pins_0_3_config_q[2*p+1]);
          tach_in_q[p] <= 1'b0;
        end else begin
          io_pin_out_q[p] <= 1'b0;
          io_pin_oe_n_q[p] <= 1'b1;
          io_state_q[p] <= 1'b0;
          tach_in_q[p] <= pin_level_q[p];
        end
      end
    end
  end

  assign pin_state = {3'h0, general_io_16_state_q, io_state_q};

  // ==========================================================
  // Intrusion clear and reference select
  always @(posedge clock) begin
    if (!rst_n) begin
      chassis_intrusion_latch_clear_q <= 1'b0;
      vref_high_sel_q <= 1'b0;
    end else begin
      // clear held as a level while the bit reads 1
      chassis_intrusion_latch_clear_q <= pin_and_reference_config_q[`FOG_CFG3_CI_CLEAR_BIT];
      vref_high_sel_q <= pin_and_reference_config_q[`FOG_CFG3_VREF_BIT];
    end
  end

endmodule // fog_config_regs

// File: fog_config_regs_props.sv
/* Assertions for the fan output and pin configuration bank.
   Assumes it sees only the bank's ports and that the bank is reset in step with it. */
`timescale 1ns/1ps

module fog_props #(
  parameter IO_PINS = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  // Fan outputs
  input wire [7:0] auto_dac_level,
  input wire [3:0] dac_min_speed_q,
  input wire [7:0] dac_level_q,
  // Pins
  input wire thermal_alarm_req,
  input wire general_io_16_value,
  input wire pin16_out_q,
  input wire pin16_oe_n_q,
  input wire [IO_PINS-1:0] io_value,
  input wire [IO_PINS-1:0] io_pin_out_q,
  input wire [IO_PINS-1:0] io_pin_oe_n_q,
  // Controls
  input wire chassis_intrusion_latch_clear_q,
  input wire vref_high_sel_q
);
  // ==========================================================
  // Shadow registers
  // Only the bits that steer outputs are mirrored, to keep this small
  reg dac_auto_q;
  reg [3:0] en_q;
  reg [7:0] lvl_q, cfg3_q, io_q;
  wire [3:0] dir = {io_q[6], io_q[4], io_q[2], io_q[0]};
  wire [3:0] pol = {io_q[7], io_q[5], io_q[3], io_q[1]};
  always @(posedge clock) begin
    if (!rst_n) begin
      dac_auto_q <= 1'b0;
      en_q <= 4'h0;
      lvl_q <= 8'hFF;
      cfg3_q <= 8'h00;
      io_q <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h00: dac_auto_q <= reg_wdata[5];
        8'h01: en_q <= reg_wdata[3:0];
        8'h04: lvl_q <= reg_wdata;
        8'h07: cfg3_q <= reg_wdata & 8'hC7;
        8'h08: io_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !reg_rd |=> reg_rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_cfg3_zero; reg_rd && reg_addr == 8'h07 |=> reg_rdata_q[5:3] == 3'b000; endproperty
  a_cfg3_zero: assert property (p_cfg3_zero) else $error("unused bits not zero");
  property p_ci; 1 |=> chassis_intrusion_latch_clear_q == $past(cfg3_q[1]); endproperty
  a_ci: assert property (p_ci) else $error("intrusion clear wrong");
  property p_vref; 1 |=> vref_high_sel_q == $past(cfg3_q[2]); endproperty
  a_vref: assert property (p_vref) else $error("reference select wrong");
  property p_dac; 1 |=> dac_level_q == ($past(dac_auto_q) ? $past(auto_dac_level) : $past(lvl_q)); endproperty
  a_dac: assert property (p_dac) else $error("analog level wrong");
  property p_dac_min; 1 |=> dac_min_speed_q == $past(lvl_q[7:4]); endproperty
  a_dac_min: assert property (p_dac_min) else $error("analog floor wrong");
  property p_thermal_alarm_output; !cfg3_q[0] |=> !pin16_out_q && pin16_oe_n_q == !$past(thermal_alarm_req); endproperty
  a_thermal_alarm_output: assert property (p_thermal_alarm_output) else $error("thermal pin wrong");
  property p_g16_out;
    cfg3_q[0] && cfg3_q[6] |=> !pin16_oe_n_q && pin16_out_q == ($past(general_io_16_value) ~^ $past(cfg3_q[7]));
  endproperty
  a_g16_out: assert property (p_g16_out) else $error("pin 16 drive wrong");
  property p_g16_in; cfg3_q[0] && !cfg3_q[6] |=> pin16_oe_n_q; endproperty
  a_g16_in: assert property (p_g16_in) else $error("pin 16 not released");
  property p_io_oe; 1 |=> io_pin_oe_n_q == ~($past(en_q) & $past(dir)); endproperty
  a_io_oe: assert property (p_io_oe) else $error("pin enables wrong");
  property p_io_out; 1 |=> ((io_pin_out_q ^ ~($past(io_value) ^ $past(pol))) & ~io_pin_oe_n_q) == 4'h0; endproperty
  a_io_out: assert property (p_io_out) else $error("pin levels wrong");
  c_auto: cover property (dac_auto_q);
  c_g16: cover property (cfg3_q[0] && cfg3_q[6]);
  c_ci: cover property (cfg3_q[1]);
endmodule // fog_props

bind fog_config_regs fog_props #(.IO_PINS(IO_PINS)) u_props (.clock, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata_q, .auto_dac_level, .dac_min_speed_q, .dac_level_q, .thermal_alarm_req,
  .general_io_16_value, .pin16_out_q, .pin16_oe_n_q, .io_value, .io_pin_out_q, .io_pin_oe_n_q,
  .chassis_intrusion_latch_clear_q, .vref_high_sel_q);

// File: fog_host_model.sv
/* Host controller model driving the register port.
   Assumes the caller enters xfer just after a rising clock edge. */
`timescale 1ns/1ps

module fog_host_model (
  // Clock
  input wire clock,
  // Register port
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One bus cycle; strobes are left for the next call to change
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w && a != 8'h06;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
endmodule // fog_host_model

// File: test_fog_config_regs.sv
/* Self-checking bench for the fan output and pin configuration bank.
   Assumes short prescaler and duty counts set through parameters. */
`timescale 1ns/1ps

module test_fog_config_regs;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] auto_dac_level = 8'h00;
  reg [3:0] auto_pwm_code = 4'h0, io_value = 4'h0, io_ext = 4'h0;
  reg thermal_alarm_req = 1'b0, general_io_16_value = 1'b0, pin16_ext = 1'b1;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q, dac_level_q, factory_byte_q;
  wire reg_wr, reg_rd, pwm_out_q, pin16_in, pin16_out_q, pin16_oe_n_q, general_io_16_state_q;
  wire chassis_intrusion_latch_clear_q, vref_high_sel_q;
  wire [3:0] dac_min_speed_q, pwm_min_speed_q, fan_tick, tach_in_q, io_state_q;
  wire [3:0] io_pin_in, io_pin_out_q, io_pin_oe_n_q;
  int errors = 0, comparisons = 0, i;
  reg [31:0] seed = 32'h00009AFD;
  reg [7:0] ex_q [$];
  reg [7:0] d, e, n;
  reg [7:0] tk [4];
  reg rd_seen = 1'b0;
  logic [7:0] addrs [7] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08};
  logic [7:0] masks [7] = '{8'h60, 8'h0F, 8'hFF, 8'hFF, 8'hF0, 8'hC7, 8'hFF};
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h7, 4'hF};

  always #5 clock = ~clock;
  // Pin wires: the bank wins where it drives, otherwise the outside level
  assign pin16_in = pin16_oe_n_q ? pin16_ext : pin16_out_q;
  assign io_pin_in = (io_pin_oe_n_q & io_ext) | (~io_pin_oe_n_q & io_pin_out_q);

  fog_host_model host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  fog_config_regs #(.BASE_DIV(8), .PWM_STEP_CYC(2)) dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .auto_dac_level, .auto_pwm_code, .dac_min_speed_q, .pwm_min_speed_q,
    .dac_level_q, .pwm_out_q, .fan_tick, .tach_in_q, .thermal_alarm_req, .general_io_16_value,
    .general_io_16_state_q, .pin16_in, .pin16_out_q, .pin16_oe_n_q, .io_value, .io_state_q, .io_pin_in,
    .io_pin_out_q, .io_pin_oe_n_q, .chassis_intrusion_latch_clear_q, .vref_high_sel_q, .factory_byte_q);

  // ==========================================================
  // Helpers
  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.xfer(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    ex_q.push_back(v);
    host.xfer(1'b0, 1'b1, a, rnd());
  endtask
  task automatic idle(input int c);
    repeat (c) host.xfer(1'b0, 1'b0, rnd(), rnd());
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) begin
      check(reg_rdata_q, ex_q.pop_front());
    end
    rd_seen <= reg_rd && rst_n;
  end

  initial begin
    #400000;
    errors++;
    summarize();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(8'h03, 8'h55);
    rd(8'h04, 8'hFF);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    idle(1);
    check(dac_level_q, 8'hFF);
    check({1'b0, vref_high_sel_q, chassis_intrusion_latch_clear_q, pin16_oe_n_q, io_pin_oe_n_q}, 8'h1F);
    check(factory_byte_q, 8'h00);
    wr(8'h02, rnd());
    rd(8'h02, 8'h00);
    for (i = 0; i < 35; i++) begin
      d = rnd();
      wr(addrs[i % 7], d);
      rd(addrs[i % 7], d & masks[i % 7]);
    end
    // Analog level, manual then automatic
    d = rnd();
    wr(8'h00, 8'h00);
    wr(8'h04, d);
    idle(2);
    check(dac_level_q, d);
    check({dac_min_speed_q, 4'h0}, d & 8'hF0);
    auto_dac_level <= ~d;
    wr(8'h00, 8'h20);
    idle(2);
    check(dac_level_q, ~d);
    // Duty over two whole periods of 15 slots of 2 cycles
    for (i = 0; i < 5; i++) begin
      wr(8'h00, i == 4 ? 8'h40 : 8'h00);
      wr(8'h05, {codes[i % 4], 4'h0});
      auto_pwm_code <= 4'h3;
      idle(70);
      n = 8'h00;
      repeat (60) begin
        @(posedge clock);
        n += pwm_out_q;
      end
      check(n, i == 4 ? 8'h0C : {2'b00, codes[i % 4], 2'b00});
      check({4'h0, pwm_min_speed_q}, {4'h0, codes[i % 4]});
    end
    // Tach ticks: ratios 1, 2, 4, 8 over 32 base ticks
    wr(8'h03, 8'hE4);
    idle(80);
    for (i = 0; i < 4; i++) tk[i] = 8'h00;
    repeat (256) begin
      @(posedge clock);
      for (i = 0; i < 4; i++) tk[i] += fan_tick[i];
    end
    for (i = 0; i < 4; i++) check(tk[i], 8'h20 >> i);
    // Pins 0 to 3
    wr(8'h01, 8'h00);
    io_ext <= 4'hA;
    idle(8);
    check({4'h0, tach_in_q}, 8'h0A);
    wr(8'h01, 8'h0F);
    d = rnd();
    e = rnd();
    io_value <= e[3:0];
    wr(8'h08, d);
    idle(6);
    check({4'h0, io_pin_oe_n_q}, {4'h0, ~{d[6], d[4], d[2], d[0]}});
    check({4'h0, tach_in_q}, 8'h00);
    // Outputs report the driven value, inputs the outside level through polarity
    n = 8'h00;
    for (i = 0; i < 4; i++) n[i] = d[2*i] ? e[i] : ~(io_ext[i] ^ d[2*i+1]);
    check({4'h0, io_state_q}, {4'h0, n[3:0]});
    // Pin 16 as output in all polarity and value pairs
    for (i = 0; i < 4; i++) begin
      general_io_16_value <= i[0];
      wr(8'h07, {i[1], 7'h41});
      idle(3);
      check({6'h00, pin16_oe_n_q, pin16_out_q}, {7'h00, ~(i[0] ^ i[1])});
      check({7'h00, general_io_16_state_q}, {7'h00, i[0]});
    end
    // Pin 16 as an active-low input seeing a low level
    pin16_ext <= 1'b0;
    wr(8'h07, 8'h01);
    idle(8);
    check({6'h00, pin16_oe_n_q, general_io_16_state_q}, 8'h03);
    thermal_alarm_req <= 1'b1;
    wr(8'h07, 8'h00);
    idle(3);
    check({6'h00, pin16_oe_n_q, pin16_out_q}, 8'h00);
    thermal_alarm_req <= 1'b0;
    wr(8'h07, 8'h06);
    idle(8);
    check({6'h00, chassis_intrusion_latch_clear_q, vref_high_sel_q}, 8'h03);
    wr(8'h07, 8'h00);
    idle(3);
    check({6'h00, chassis_intrusion_latch_clear_q, vref_high_sel_q}, 8'h00);
    rd(8'h1F, {4'h0, n[3:0]});
    idle(2);
    summarize();
  end
endmodule // test_fog_config_regs
